// file: calendar_clock_port.sv
// calendar clock port: shared output latch, serial time register, pulse generator
// assumes a cpu access bus on the core clock; power-fail line comes from a pin
//
// Contract
// - port read returns time register serial output on bit 0
// - port read returns the timed_pulse level on bit 1
// - written bit 0 is serial input, bit 1 is shift clock
// - capture on rising shift clock edge, advance output on falling edge
// - command lines on bits 2..4, command_strobe on bit 5
// - command_line_2 high selects pulse rate, low selects clock commands
// - codes 000 hold, 001 shift, 010 load clock, 011 copy clock
// - codes 100/101/110 give 64/256/2048 Hz, 111 gives 32 Hz test
// - after power-up the chip is in test mode at 32 Hz
// - clock commands blocked while in test mode
// - chip select high except on power failure
// - output enable high except on power failure
// - clock uses six port bits, the upper two go to printer
// - time register shifts least significant bit first
// - rising timed_pulse sets a latch driving level interrupt request
// - a port read clears the interrupt latch unless a pulse edge sets it in the same cycle
`include "calendar_clock_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module calendar_clock_port
    import calendar_clock_pkg::*;
(
    input  wire logic       CORE_CLK_I,
    input  wire logic       RESET_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic [7:0] WDATA_I,
    output logic      [7:0] RDATA_O,
    output logic            WR_READY_O,
    input  wire logic       POWER_FAIL_I,
    output logic            RIBBON_LIFT_O,
    output logic            PRINTER_SELECT_O,
    output logic            CHIP_SELECT_O,
    output logic            OUTPUT_ENABLE_O,
    output logic            TIMED_PULSE_IRQ_O
);
    logic                   wr_hit;
    logic                   rd_hit;
    logic                   f_valid;
    logic [7:0]             f_data;
    logic                   f_ready;
    logic [7:0]             port_ff;
    logic [1:0]             pf_sync_ff;
    logic [`TIME_BITS-1:0]  shreg_ff;
    logic [`TIME_BITS-1:0]  time_ff;
    logic                   serial_out_ff;
    logic                   clk_prev_ff;
    logic                   stb_prev_ff;
    logic                   shift_en_ff;
    pulse_rate_t            rate_ff;
    logic [15:0]            div_ff;
    logic [6:0]             base_ff;
    logic                   tp_ff;
    logic                   tp_prev_ff;
    logic                   irq_ff;
    logic [7:0]             rdata_ff;
    logic                   pulse_tap;
    logic                   stb_rise;
    logic [2:0]             code;
    logic [`TIME_BITS-1:0]  time_inc;
    logic                   time_tick;

    assign wr_hit = WR_I && (ADDR_I == `CLOCK_PORT_OFFSET);
    assign rd_hit = RD_I && (ADDR_I == `CLOCK_PORT_OFFSET);
    assign code   = port_ff[`BIT_CMD2:`BIT_CMD0];
    // one byte drained per cycle; the fifo only fills if writes outrun it
    assign f_ready = 1'b1;

    port_fifo #(
        .WIDTH (8),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CORE_CLK_I),
        .rst_i       (RESET_I),
        .in_valid_i  (wr_hit),
        .in_ready_o  (),
        .in_data_i   (WDATA_I),
        .out_valid_o (f_valid),
        .out_ready_i (f_ready),
        .out_data_o  (f_data)
    );

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            WR_READY_O <= 1'b0;
        end else begin
            WR_READY_O <= 1'b1;
        end
    end

    // all eight bits held until the next write
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            port_ff <= `PORT_RESET;
        end else if (f_valid) begin
            port_ff <= f_data;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            RIBBON_LIFT_O    <= 1'b0;
            PRINTER_SELECT_O <= 1'b0;
        end else begin
            RIBBON_LIFT_O    <= port_ff[6];
            PRINTER_SELECT_O <= port_ff[7];
        end
    end

    // power-fail pin is asynchronous
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            pf_sync_ff <= 2'b00;
        end else begin
            pf_sync_ff <= {pf_sync_ff[0], POWER_FAIL_I};
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            CHIP_SELECT_O   <= 1'b0;
            OUTPUT_ENABLE_O <= 1'b0;
        end else begin
            CHIP_SELECT_O   <= !pf_sync_ff[1];
            OUTPUT_ENABLE_O <= !pf_sync_ff[1];
        end
    end

    assign stb_rise = CHIP_SELECT_O && port_ff[`BIT_STROBE] && !stb_prev_ff;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            stb_prev_ff <= 1'b0;
            clk_prev_ff <= 1'b0;
        end else begin
            stb_prev_ff <= port_ff[`BIT_STROBE];
            clk_prev_ff <= port_ff[`BIT_SHIFT_CLK];
        end
    end

    // command decode on strobe rising edge
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            rate_ff <= RATE_TEST;
        end else if (stb_rise && code[2]) begin
            case (code[1:0])
                2'h0:    rate_ff <= RATE_64;
                2'h1:    rate_ff <= RATE_256;
                2'h2:    rate_ff <= RATE_2048;
                default: rate_ff <= RATE_TEST;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            shift_en_ff <= 1'b0;
        end else if (stb_rise && !code[2] && rate_ff != RATE_TEST) begin
            shift_en_ff <= (code[1:0] == 2'h1);
        end
    end

    // time counter kept binary, stepping 32 times a second except at the 2048 Hz rate; the host formats the fields
    assign time_inc = time_ff + `TIME_BITS'(1);
    // one tick per wrap of the base counter, none at 2048 Hz where tp_ff is low then; a load in the same cycle wins
    assign time_tick = (base_ff == 7'h7F) && (div_ff == 16'h0) && tp_ff;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            time_ff <= '0;
        end else if (stb_rise && !code[2] && rate_ff != RATE_TEST
                     && code[1:0] == 2'h2) begin
            time_ff <= shreg_ff;
        end else if (time_tick) begin
            time_ff <= time_inc;
        end
    end

    // lsb enters at the top and leaves from bit 0 first
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            shreg_ff      <= '0;
            serial_out_ff <= 1'b0;
        end else if (stb_rise && !code[2] && rate_ff != RATE_TEST
                     && code[1:0] == 2'h3) begin
            shreg_ff      <= time_ff;
            serial_out_ff <= time_ff[0];
        end else if (shift_en_ff && CHIP_SELECT_O) begin
            if (port_ff[`BIT_SHIFT_CLK] && !clk_prev_ff) begin
                shreg_ff <= {port_ff[`BIT_DATA_IN],
                             shreg_ff[`TIME_BITS-1:1]};
            end
            if (!port_ff[`BIT_SHIFT_CLK] && clk_prev_ff) begin
                serial_out_ff <= shreg_ff[0];
            end
        end
    end

    // base counter steps at 4096 Hz; each tap bit up halves the rate again
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            div_ff  <= '0;
            base_ff <= '0;
        end else if (div_ff == 16'(`BASE_DIV - 1)) begin
            div_ff  <= '0;
            base_ff <= base_ff + 7'h01;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    always_comb begin
        case (rate_ff)
            RATE_64:   pulse_tap = base_ff[5];
            RATE_256:  pulse_tap = base_ff[3];
            RATE_2048: pulse_tap = base_ff[0];
            RATE_TEST: pulse_tap = base_ff[6];
            default:   pulse_tap = base_ff[6];
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            tp_ff      <= 1'b0;
            tp_prev_ff <= 1'b0;
        end else begin
            tp_ff      <= pulse_tap;
            tp_prev_ff <= tp_ff;
        end
    end

    // a new pulse edge beats a clearing read in the same cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            irq_ff <= 1'b0;
        end else if (tp_ff && !tp_prev_ff) begin
            irq_ff <= 1'b1;
        end else if (rd_hit) begin
            irq_ff <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            TIMED_PULSE_IRQ_O <= 1'b0;
        end else begin
            TIMED_PULSE_IRQ_O <= irq_ff;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= {6'h00,
                         tp_ff && OUTPUT_ENABLE_O,
                         serial_out_ff && OUTPUT_ENABLE_O};
        end
    end

    assign RDATA_O = rdata_ff;

    irq_set_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (tp_ff && !tp_prev_ff) |=> ##1 TIMED_PULSE_IRQ_O)
        else $error("pulse edge did not raise interrupt");
    irq_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (rd_hit && !(tp_ff && !tp_prev_ff)) |=> !irq_ff)
        else $error("read did not clear interrupt latch");
    test_lock_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (stb_rise && !code[2] && rate_ff == RATE_TEST && !time_tick)
        |=> $stable(time_ff) && $stable(shift_en_ff))
        else $error("clock command ran in test mode");
    rate_pick_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (stb_rise && code == 3'h5) |=> rate_ff == RATE_256)
        else $error("rate command not applied");
    port_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        !f_valid |=> $stable(port_ff))
        else $error("port latch changed without write");
    shift_in_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (shift_en_ff && CHIP_SELECT_O && port_ff[1] && !clk_prev_ff && !stb_rise)
        |=> shreg_ff[`TIME_BITS-1] == $past(port_ff[0]))
        else $error("shift register missed serial input");
    cs_fail_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        pf_sync_ff[1] |=> !CHIP_SELECT_O && !OUTPUT_ENABLE_O)
        else $error("chip select held during power failure");
    read_bits_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        ##1 RDATA_O[1] == $past(tp_ff && OUTPUT_ENABLE_O))
        else $error("read data bit 1 not timed pulse");

    // command effects, shift direction and the read-back path
    load_clock_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (stb_rise && !code[2] && rate_ff != RATE_TEST && code[1:0] == 2'h2)
        |=> time_ff == $past(shreg_ff))
        else $error("load command did not set the time");
    copy_clock_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (stb_rise && !code[2] && rate_ff != RATE_TEST && code[1:0] == 2'h3)
        |=> shreg_ff == $past(time_ff) && serial_out_ff == $past(time_ff[0]))
        else $error("copy command did not capture the time");
    shift_mode_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (stb_rise && !code[2] && rate_ff != RATE_TEST)
        |=> shift_en_ff == ($past(code[1:0]) == 2'h1))
        else $error("shift enable not taken from command");
    shift_out_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (shift_en_ff && CHIP_SELECT_O && !port_ff[1] && clk_prev_ff && !stb_rise)
        |=> serial_out_ff == $past(shreg_ff[0]))
        else $error("serial output did not advance on falling edge");
    shift_lsb_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (shift_en_ff && CHIP_SELECT_O && port_ff[1] && !clk_prev_ff && !stb_rise)
        |=> shreg_ff[`TIME_BITS-2:0] == $past(shreg_ff[`TIME_BITS-1:1]))
        else $error("shift register moved the wrong way");
    rate_low_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (stb_rise && code == 3'h4) |=> rate_ff == RATE_64)
        else $error("64 Hz rate not applied");
    rate_fast_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (stb_rise && code == 3'h6) |=> rate_ff == RATE_2048)
        else $error("2048 Hz rate not applied");
    rate_test_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (stb_rise && code == 3'h7) |=> rate_ff == RATE_TEST)
        else $error("test mode not entered");
    rate_keep_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (stb_rise && !code[2]) |=> $stable(rate_ff))
        else $error("clock command changed the pulse rate");
    port_load_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        f_valid |=> port_ff == $past(f_data))
        else $error("port latch missed a write");
    printer_bits_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        1'b1 |=> RIBBON_LIFT_O == $past(port_ff[6])
                 && PRINTER_SELECT_O == $past(port_ff[7]))
        else $error("printer lines do not follow port bits");
    run_select_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        !pf_sync_ff[1] |=> CHIP_SELECT_O && OUTPUT_ENABLE_O)
        else $error("select or enable low without power failure");
    fail_block_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        !CHIP_SELECT_O |=> $stable(shreg_ff) && $stable(rate_ff))
        else $error("chip reacted while deselected");
    irq_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (irq_ff && !rd_hit) |=> irq_ff)
        else $error("interrupt latch dropped without a read");
    read_bit0_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        ##1 RDATA_O[0] == $past(serial_out_ff && OUTPUT_ENABLE_O))
        else $error("read data bit 0 not serial output");
    read_zero_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        1'b1 |=> RDATA_O[7:2] == 6'h00)
        else $error("unused read bits not zero");
endmodule
`default_nettype wire

// file: calendar_clock_defines.svh
// constants for the calendar clock port: offsets, bit positions, timing counts
// assumes a 10 MHz core clock and an 8-bit port access bus
`ifndef CALENDAR_CLOCK_DEFINES_SVH
`define CALENDAR_CLOCK_DEFINES_SVH
`define CLOCK_PORT_OFFSET   8'h02
`define BIT_DATA_IN         0
`define BIT_SHIFT_CLK       1
`define BIT_CMD0            2
`define BIT_CMD1            3
`define BIT_CMD2            4
`define BIT_STROBE          5
`define BIT_DATA_OUT        0
`define BIT_TIMED_PULSE     1
`define TIME_BITS           40
`define PORT_RESET          8'h00
`define CORE_CLK_HZ         10000000
`define BASE_HZ             4096
`define BASE_DIV            (`CORE_CLK_HZ / `BASE_HZ)
`define FIFO_DEPTH          4
`endif

// file: calendar_clock_pkg.sv
// types for the calendar clock port
// assumes the defines header is included by users of constants
package calendar_clock_pkg;
    typedef enum logic [1:0] {
        RATE_64,
        RATE_256,
        RATE_2048,
        RATE_TEST
    } pulse_rate_t;
    typedef enum logic [1:0] {
        MODE_HOLD,
        MODE_SHIFT,
        MODE_SET,
        MODE_READ
    } clock_mode_t;
endpackage

// file: port_fifo.sv
// small valid/ready fifo for written port bytes
// assumes a single clock and synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module port_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;
    assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o  = mem_ff[rd_ff];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// file: host_cpu_model.sv
// host cpu model: drives the shared clock port with byte writes and reads
// assumes one write or read pulse per access, driven 10 ns after the clock edge
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] wdata_o
);
    logic [1:0] upper = 2'h0;
    initial begin
        addr_o  = 8'h02;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 8'h00;
    end
    // data lines show the inverse once released, so a late sample cannot pass by luck
    task automatic port_write(input logic [7:0] addr, input logic [7:0] val);
        @(posedge clk_i);
        #10;
        addr_o  = addr;
        wdata_o = val;
        wr_o    = 1'b1;
        @(posedge clk_i);
        #10;
        wr_o    = 1'b0;
        wdata_o = ~val;
        repeat (4) @(posedge clk_i);
        #10;
    endtask
    task automatic port_read();
        @(posedge clk_i);
        #10;
        addr_o = 8'h02;
        rd_o   = 1'b1;
        @(posedge clk_i);
        #10;
        rd_o = 1'b0;
    endtask
    task automatic clk_write(input logic [5:0] low6);
        port_write(8'h02, {upper, low6});
    endtask
    task automatic strobe_cmd(input logic [2:0] code);
        clk_write({1'b0, code, 2'b00});
        clk_write({1'b1, code, 2'b00});
        clk_write({1'b0, code, 2'b00});
    endtask
    task automatic shift_in(input logic [39:0] t);
        strobe_cmd(3'h1);
        for (int i = 0; i < 40; i++) begin
            clk_write({4'h0, 1'b0, t[i]});
            clk_write({4'h0, 1'b1, t[i]});
            clk_write({4'h0, 1'b0, t[i]});
        end
        strobe_cmd(3'h2);
    endtask
    task automatic shift_out(output logic [39:0] t);
        strobe_cmd(3'h3);
        strobe_cmd(3'h1);
        for (int i = 0; i < 40; i++) begin
            t[i] = rdata_i[0];
            clk_write(6'h02);
            clk_write(6'h00);
        end
    endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// testbench for the calendar clock port: host model, behavioural time model
// assumes the time counter does not tick during the short read-back windows
`include "calendar_clock_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        power_fail = 1'b0;
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        wr_ready;
    logic        ribbon;
    logic        prn_sel;
    logic        chip_sel;
    logic        out_en;
    logic        irq;
    int          n_fail    = 0;
    int          tests_run = 0;
    int          cycles    = 0;
    int          rate_ok   = 0;
    int          period;
    logic [39:0] mdl_time = '0;
    logic [39:0] got;
    logic [39:0] val_x;
    logic [39:0] val_y;
    always #50 core_clk = ~core_clk;
    calendar_clock_port calendar_clock_port_i (
        .CORE_CLK_I        (core_clk),
        .RESET_I           (reset),
        .ADDR_I            (addr),
        .WR_I              (wr),
        .RD_I              (rd),
        .WDATA_I           (wdata),
        .RDATA_O           (rdata),
        .WR_READY_O        (wr_ready),
        .POWER_FAIL_I      (power_fail),
        .RIBBON_LIFT_O     (ribbon),
        .PRINTER_SELECT_O  (prn_sel),
        .CHIP_SELECT_O     (chip_sel),
        .OUTPUT_ENABLE_O   (out_en),
        .TIMED_PULSE_IRQ_O (irq)
    );
    host_cpu_model host_cpu_model_i (
        .clk_i   (core_clk),
        .rdata_i (rdata),
        .addr_o  (addr),
        .wr_o    (wr),
        .rd_o    (rd),
        .wdata_o (wdata)
    );
    task automatic print_verdict();
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check_eq(input logic [39:0] g, input logic [39:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic check_in(input int g, input int lo, input int hi);
        tests_run++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, lo);
        end
    endtask
    // counts cycles until the pulse bit moves to lvl; bounded so a dead divider is caught
    task automatic wait_edge(input logic lvl, output int n);
        logic prev;
        n = 0;
        prev = rdata[1];
        while (n < 25000 && !(prev === !lvl && rdata[1] === lvl)) begin
            prev = rdata[1];
            @(posedge core_clk);
            #10;
            n++;
        end
    endtask
    // model: clock-group commands count only once a real rate is chosen
    task automatic mdl_rate(input logic [2:0] code);
        rate_ok = (code != 3'h7) ? 1 : 0;
        host_cpu_model_i.strobe_cmd(code);
    endtask
    task automatic mdl_set(input logic [39:0] t);
        host_cpu_model_i.shift_in(t);
        if (rate_ok != 0) begin
            mdl_time = t;
        end
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(30));
        val_x = 40'({$urandom, $urandom});
        val_y = ~val_x;
        repeat (3) @(posedge core_clk);
        #10;
        reset = 1'b0;
        repeat (5) @(posedge core_clk);
        #10;
        check_eq(chip_sel, 1'b1);
        check_eq(out_en, 1'b1);
        check_eq(irq, 1'b0);
        check_eq(wr_ready, 1'b1);
        check_eq(rdata[7:2], 6'h00);
        power_fail = 1'b1;
        repeat (5) @(posedge core_clk);
        #10;
        check_eq({chip_sel, out_en}, 2'h0);
        power_fail = 1'b0;
        repeat (5) @(posedge core_clk);
        #10;
        check_eq({chip_sel, out_en}, 2'h3);
        host_cpu_model_i.upper = 2'($urandom);
        host_cpu_model_i.clk_write(6'h00);
        check_eq({prn_sel, ribbon}, host_cpu_model_i.upper);
        host_cpu_model_i.port_write(8'h03, {~host_cpu_model_i.upper, 6'h3F});
        check_eq({prn_sel, ribbon}, host_cpu_model_i.upper);
        // power-up test mode: this set must be ignored
        mdl_set(val_y);
        mdl_rate(3'h4);
        mdl_set(val_x);
        host_cpu_model_i.strobe_cmd(3'h0);
        host_cpu_model_i.shift_out(got);
        check_eq(got, mdl_time);
        mdl_rate(3'h7);
        mdl_set(val_y);
        mdl_rate(3'h5);
        wait_edge(!rdata[1], period);
        wait_edge(!rdata[1], period);
        check_in(period, `CORE_CLK_HZ / 512 - 50, `CORE_CLK_HZ / 512 + 50);
        host_cpu_model_i.shift_out(got);
        check_eq(got, mdl_time);
        check_eq({prn_sel, ribbon}, host_cpu_model_i.upper);
        mdl_rate(3'h6);
        wait_edge(1'b1, period);
        host_cpu_model_i.port_read();
        wait_edge(1'b1, period);
        repeat (2) @(posedge core_clk);
        #10;
        check_eq({irq, rdata[1]}, 2'h3);
        host_cpu_model_i.port_read();
        repeat (2) @(posedge core_clk);
        #10;
        check_eq(irq, 1'b0);
        wait_edge(1'b1, period);
        check_in(period, `CORE_CLK_HZ / 2048 - 50, `CORE_CLK_HZ / 2048 + 50);
        print_verdict();
    end
endmodule
`default_nettype wire
